// File: logic/fault_flags_defs.svh
`ifndef FAULT_FLAGS_DEFS_SVH
`define FAULT_FLAGS_DEFS_SVH
// What this block does
// [R1] io supply low flag: set below falling, clear above rising or on wake
// [R2] battery low flag is internal; recovery above rising counts as cold start
// [R3] bus short flag needs fault on four tx releases; reported in normal only
// [R4] bus short flag clears leaving normal or after four clean releases
// [R5] tx low on entering active mode clamps driver off; receiver stays on
// [R6] tx held dominant past limit time disables driver until cleared
// [R7] tx timeout clears on rx low with tx high, or tx high plus mode change other than into silent
// [R8] tx and rx shorted past limit time disables driver until cleared
// [R9] local faults reach fault output only on entering silent from normal
// [R10] bus stuck dominant flag keeps driver on; clears on rx high or mode change not into silent
// [R11] overtemp disables driver; clears when cool with rx low, tx high, or mode change not into silent
// [R12] going to go-to-sleep is held off while wake request flag is set
// [R13] first wake source is latched until its flag clears
// [R14] wake source shown on fault output only in normal, until cleared
// [R15] cold start sets power-up flag; shown entering silent from standby/sleep
// [R16] power-up flag clears on entering normal
// [R17] all indications are ORed onto the low-active fault output; rx shows wake
// [R18] in normal, local wake shows fault low, remote wake shows fault high
// [R19] any mode change but normal to silent clears local fault indication
// [R20] filter and timeout lengths count ticks of a free-running timebase

// clock and timebase
`define CLK_PERIOD_NS 20
`define TICK_PERIOD_NS 1000
`define TICK_DIV ((`TICK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// filter and timeout times, microseconds
`define TX_DOM_LIMIT_US 1200
`define BUS_DOM_LIMIT_US 1200
`define UV_FILTER_US 100
`define US_TO_TICKS(t) (((t) * 1000) / `TICK_PERIOD_NS)
// edge counts for bus short set/clear and wake source clear
`define CBF_EDGES 3'h4
`define WSR_EDGES 3'h4
// timer channel indices
`define TMR_TX_DOM 0
`define TMR_TX_RX 1
`define TMR_BUS_DOM 2
`define TMR_IO_UV 3
`define TMR_NUM 4
// reset values of the cold start related flags
`define COLD_START_RST 1'h1
`define WAKE_REQ_RST 1'h1
`define WAKE_SRC_RST 1'h1
`define WAKE_LOCAL_RST 1'h1
`endif

// File: logic/fault_flags_pkg.sv
package fault_flags_pkg;
   // operating modes
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_SILENT,
      MODE_STANDBY,
      MODE_GO_SLEEP,
      MODE_SLEEP
   } mode_t;

   // analog detector levels and pins from outside the clock domain
   typedef struct packed {
      logic txd;         // tx pin, high is recessive
      logic bus_dom;     // bus receiver sees dominant
      logic bus_short;   // bus short comparator
      logic tx_rx_short; // tx and rx pins tied together
      logic ot_hot;      // junction above shutdown threshold
      logic ot_cool;     // junction below release threshold
      logic io_low;      // io supply below falling threshold
      logic io_ok;       // io supply above rising threshold
      logic bat_low;     // battery below falling threshold
      logic bat_ok;      // battery above rising threshold
   } analog_in_t;

   // status flags
   typedef struct packed {
      logic io_supply_low_flag;
      logic battery_supply_low_flag;
      logic bus_short_flag;
      logic tx_clamped_flag;
      logic tx_dominant_timeout_flag;
      logic tx_rx_short_flag;
      logic bus_stuck_dominant_flag;
      logic overtemp_flag;
      logic cold_start_flag;
      logic wake_request_flag;
      logic wake_source_flag;
   } flags_t;
endpackage : fault_flags_pkg

// File: logic/can_phy_fault_status_flags.sv
`timescale 1ns/1ns
`include "fault_flags_defs.svh"
module can_phy_fault_status_flags
   import fault_flags_pkg::*;
#(
   parameter int TW = 16,
   parameter int TICK_DIV = `TICK_DIV,
   parameter int TX_DOM_TICKS = `US_TO_TICKS(`TX_DOM_LIMIT_US),
   parameter int BUS_DOM_TICKS = `US_TO_TICKS(`BUS_DOM_LIMIT_US),
   parameter int UV_TICKS = `US_TO_TICKS(`UV_FILTER_US)
) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire mode_t mode_req,
   input wire analog_in_t raw_in,
   input wire logic local_wake_evt,
   input wire logic remote_wake_evt,
   output mode_t mode,
   output logic fault_out_n,
   output logic rxd_out,
   output logic bus_drive_dominant,
   output logic bus_driver_en,
   output logic wake_src_local,
   output flags_t flags
);

   // two-stage synchroniser for all outside levels
   analog_in_t sync1_q;
   analog_in_t sync2_q;
   always_ff @(posedge core_clk) begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
   end

   // free-running timebase divider
   logic [TW-1:0] div_q;
   logic [TW-1:0] div_d;
   logic tick;
   always_comb begin
      tick = (div_q == TW'(TICK_DIV - 1));
      div_d = tick ? '0 : div_q + 1'b1;
      if (!resetn) begin
         div_d = '0;
      end
   end
   always_ff @(posedge core_clk) begin
      div_q <= div_d;
   end

   // state registered by the main process
   mode_t mode_q;
   mode_t mode_d;
   flags_t fl_q;
   flags_t fl_d;
   logic local_q, local_d;
   logic [2:0] bad_q, bad_d;
   logic [2:0] good_q, good_d;
   logic seen_q, seen_d;
   logic [2:0] wsr_q, wsr_d;
   logic txd_prev_q, txd_prev_d;
   logic local_rep_q, local_rep_d;
   logic cold_rep_q, cold_rep_d;
   logic fault_n_q, fault_n_d;
   logic rxd_q, rxd_d;
   logic drv_dom_q, drv_dom_d;
   logic drv_en_q, drv_en_d;

   // filtered durations, one tick counter per channel
   logic [`TMR_NUM-1:0] tmr_cond;
   logic [`TMR_NUM-1:0] tmr_hit;
   logic [TW-1:0] tmr_lim [`TMR_NUM];
   assign tmr_cond[`TMR_TX_DOM] = !sync2_q.txd && mode_q == MODE_NORMAL;
   assign tmr_cond[`TMR_TX_RX] = sync2_q.tx_rx_short;
   assign tmr_cond[`TMR_BUS_DOM] = sync2_q.bus_dom;
   assign tmr_cond[`TMR_IO_UV] = sync2_q.io_low;
   assign tmr_lim[`TMR_TX_DOM] = TW'(TX_DOM_TICKS); // see [R20]
   assign tmr_lim[`TMR_TX_RX] = TW'(TX_DOM_TICKS);
   assign tmr_lim[`TMR_BUS_DOM] = TW'(BUS_DOM_TICKS);
   assign tmr_lim[`TMR_IO_UV] = TW'(UV_TICKS);

   genvar g;
   generate
      for (g = 0; g < `TMR_NUM; g++) begin : g_tmr
         logic [TW-1:0] cnt_q;
         logic [TW-1:0] cnt_d;
         // count ticks while the condition holds, saturate at the limit
         always_comb begin
            cnt_d = cnt_q;
            if (!tmr_cond[g] || !resetn) begin
               cnt_d = '0;
            end else if (tick && cnt_q != tmr_lim[g]) begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         always_ff @(posedge core_clk) begin
            cnt_q <= cnt_d;
         end
         assign tmr_hit[g] = tmr_cond[g] && cnt_q == tmr_lim[g];
      end
   endgenerate

   // mode and edge events
   logic changed, into_quiet, enter_norm, leave_norm;
   logic norm_to_sil, low_to_sil, txd_rise, txd_fall;
   logic cold_evt, wake_evt, low_mode, io_uv_set, any_local, fault;
   always_comb begin
      mode_d = mode_req;
      if (mode_req == MODE_GO_SLEEP && mode_q != MODE_GO_SLEEP &&
          fl_q.wake_request_flag) begin
         mode_d = mode_q; // see [R12]
      end
      if (!resetn) begin
         mode_d = MODE_STANDBY;
      end
      changed = mode_d != mode_q;
      into_quiet = changed && mode_d != MODE_SILENT;
      enter_norm = changed && mode_d == MODE_NORMAL;
      leave_norm = changed && mode_q == MODE_NORMAL;
      norm_to_sil = leave_norm && mode_d == MODE_SILENT;
      low_to_sil = changed && mode_d == MODE_SILENT &&
                   (mode_q == MODE_STANDBY || mode_q == MODE_SLEEP);
      txd_rise = sync2_q.txd && !txd_prev_q;
      txd_fall = !sync2_q.txd && txd_prev_q;
      low_mode = mode_q == MODE_STANDBY || mode_q == MODE_GO_SLEEP ||
                 mode_q == MODE_SLEEP;
      cold_evt = fl_q.battery_supply_low_flag && sync2_q.bat_ok; // see [R2]
      wake_evt = (low_mode && (local_wake_evt || remote_wake_evt)) ||
                 cold_evt;
      io_uv_set = tmr_hit[`TMR_IO_UV] && !fl_q.io_supply_low_flag;
   end

   // flag, indicator and output next values
   always_comb begin
      fl_d = fl_q;
      local_d = local_q;
      bad_d = bad_q;
      good_d = good_q;
      seen_d = seen_q;
      wsr_d = wsr_q;
      local_rep_d = local_rep_q;
      cold_rep_d = cold_rep_q;
      txd_prev_d = sync2_q.txd;

      // io supply: filtered set, clear on recovery or wake
      if (sync2_q.io_ok || wake_evt) begin
         fl_d.io_supply_low_flag = 1'b0; // see [R1]
      end
      if (io_uv_set) begin
         fl_d.io_supply_low_flag = 1'b1; // see [R1]
      end

      // battery: recovery raises power-up, wake request and local source
      if (sync2_q.bat_ok) begin
         fl_d.battery_supply_low_flag = 1'b0;
      end
      if (sync2_q.bat_low) begin
         fl_d.battery_supply_low_flag = 1'b1; // see [R2]
      end

      // wake request: cleared by normal or io undervoltage
      if (enter_norm || io_uv_set) begin
         fl_d.wake_request_flag = 1'b0;
      end
      if (wake_evt) begin
         fl_d.wake_request_flag = 1'b1;
      end

      // wake source: counts tx falls in normal, then clears
      if (mode_q == MODE_NORMAL && txd_fall && fl_q.wake_source_flag) begin
         wsr_d = wsr_q + 1'b1;
      end
      if (leave_norm || io_uv_set || wsr_d == `WSR_EDGES) begin
         fl_d.wake_source_flag = 1'b0; // see [R14]
         wsr_d = '0;
      end
      if (wake_evt && !fl_q.wake_source_flag) begin
         fl_d.wake_source_flag = 1'b1; // see [R13]
         local_d = cold_evt || local_wake_evt;
         wsr_d = '0;
      end

      // power-up flag
      if (enter_norm) begin
         fl_d.cold_start_flag = 1'b0; // see [R16]
      end
      if (cold_evt) begin
         fl_d.cold_start_flag = 1'b1; // see [R15]
      end

      // bus short: judge each tx dominant phase at its release
      if (!sync2_q.txd && sync2_q.bus_short) begin
         seen_d = 1'b1;
      end
      if (mode_q == MODE_NORMAL && txd_rise) begin
         seen_d = 1'b0;
         if (seen_q || sync2_q.bus_short) begin
            good_d = '0;
            bad_d = (bad_q == `CBF_EDGES) ? bad_q : bad_q + 1'b1;
         end else begin
            bad_d = '0;
            good_d = (good_q == `CBF_EDGES) ? good_q : good_q + 1'b1;
         end
      end
      if (good_d == `CBF_EDGES) begin
         fl_d.bus_short_flag = 1'b0; // see [R4]
      end
      if (bad_d == `CBF_EDGES) begin
         fl_d.bus_short_flag = 1'b1; // see [R3]
      end
      if (mode_q != MODE_NORMAL || leave_norm) begin
         fl_d.bus_short_flag = 1'b0; // see [R4]
         bad_d = '0;
         good_d = '0;
         seen_d = 1'b0;
      end

      // tx clamp: sampled on entry into active mode
      any_local = fl_q.tx_dominant_timeout_flag || fl_q.tx_rx_short_flag ||
                  fl_q.overtemp_flag;
      if ((enter_norm && sync2_q.txd) ||
          (sync2_q.txd && sync2_q.bus_dom && !any_local)) begin
         fl_d.tx_clamped_flag = 1'b0;
      end
      if (enter_norm && !sync2_q.txd) begin
         fl_d.tx_clamped_flag = 1'b1; // see [R5]
      end

      // tx dominant timeout
      if (sync2_q.txd && (sync2_q.bus_dom || into_quiet)) begin
         fl_d.tx_dominant_timeout_flag = 1'b0; // see [R7]
      end
      if (tmr_hit[`TMR_TX_DOM]) begin
         fl_d.tx_dominant_timeout_flag = 1'b1; // see [R6]
      end

      // tx to rx short
      if ((sync2_q.txd && sync2_q.bus_dom) || into_quiet) begin
         fl_d.tx_rx_short_flag = 1'b0;
      end
      if (tmr_hit[`TMR_TX_RX]) begin
         fl_d.tx_rx_short_flag = 1'b1; // see [R8]
      end

      // bus stuck dominant
      if (!sync2_q.bus_dom || into_quiet) begin
         fl_d.bus_stuck_dominant_flag = 1'b0; // see [R10]
      end
      if (tmr_hit[`TMR_BUS_DOM]) begin
         fl_d.bus_stuck_dominant_flag = 1'b1; // see [R10]
      end

      // overtemperature
      if ((sync2_q.ot_cool && sync2_q.bus_dom && sync2_q.txd) ||
          into_quiet) begin
         fl_d.overtemp_flag = 1'b0; // see [R11]
      end
      if (sync2_q.ot_hot) begin
         fl_d.overtemp_flag = 1'b1; // see [R11]
      end

      // local fault indication latched only on normal to silent
      if (changed) begin
         local_rep_d = 1'b0; // see [R19]
      end
      if (norm_to_sil) begin
         local_rep_d = fl_d.tx_clamped_flag || // see [R9]
                       fl_d.tx_dominant_timeout_flag ||
                       fl_d.tx_rx_short_flag ||
                       fl_d.bus_stuck_dominant_flag || fl_d.overtemp_flag;
      end

      // power-up indication on entry to silent from standby or sleep
      if (changed) begin
         cold_rep_d = 1'b0;
      end
      if (low_to_sil && fl_d.cold_start_flag) begin
         cold_rep_d = 1'b1; // see [R15]
      end

      if (!resetn) begin
         fl_d = '0;
         fl_d.cold_start_flag = `COLD_START_RST;
         fl_d.wake_request_flag = `WAKE_REQ_RST;
         fl_d.wake_source_flag = `WAKE_SRC_RST;
         local_d = `WAKE_LOCAL_RST;
         bad_d = '0;
         good_d = '0;
         seen_d = 1'b0;
         wsr_d = '0;
         txd_prev_d = 1'b1;
         local_rep_d = 1'b0;
         cold_rep_d = 1'b0;
      end

      // fault output: OR of every indication
      fault = (mode_d == MODE_NORMAL && fl_d.bus_short_flag) || // see [R3]
              (mode_d == MODE_NORMAL && fl_d.wake_source_flag &&
               local_d) || // see [R18]
              local_rep_d || cold_rep_d; // see [R17]
      fault_n_d = !fault;

      // driver gating by the disabling faults
      drv_en_d = mode_d == MODE_NORMAL && !fl_d.tx_clamped_flag &&
                 !fl_d.tx_dominant_timeout_flag && // see [R6]
                 !fl_d.tx_rx_short_flag && !fl_d.overtemp_flag; // see [R8]
      drv_dom_d = drv_en_d && !sync2_q.txd;

      // receive output mirrors bus, or shows wake in low power modes
      if (mode_d == MODE_NORMAL || mode_d == MODE_SILENT) begin
         rxd_d = !sync2_q.bus_dom;
      end else begin
         rxd_d = !fl_d.wake_request_flag; // see [R17]
      end
      if (!resetn) begin
         fault_n_d = 1'b1;
         drv_en_d = 1'b0;
         drv_dom_d = 1'b0;
         rxd_d = 1'b1;
      end
   end

   // register all state
   always_ff @(posedge core_clk) begin
      mode_q <= mode_d;
      fl_q <= fl_d;
      local_q <= local_d;
      bad_q <= bad_d;
      good_q <= good_d;
      seen_q <= seen_d;
      wsr_q <= wsr_d;
      txd_prev_q <= txd_prev_d;
      local_rep_q <= local_rep_d;
      cold_rep_q <= cold_rep_d;
      fault_n_q <= fault_n_d;
      rxd_q <= rxd_d;
      drv_dom_q <= drv_dom_d;
      drv_en_q <= drv_en_d;
   end

   // outputs straight from flip-flops
   assign mode = mode_q;
   assign flags = fl_q;
   assign wake_src_local = local_q;
   assign fault_out_n = fault_n_q;
   assign rxd_out = rxd_q;
   assign bus_drive_dominant = drv_dom_q;
   assign bus_driver_en = drv_en_q;

endmodule : can_phy_fault_status_flags

// File: tb/fault_flags_props.sv
`timescale 1ns/1ns
module fault_flags_props
   import fault_flags_pkg::*;
(
   input wire logic core_clk,
   input wire logic resetn,
   input wire mode_t mode_req,
   input wire analog_in_t raw_in,
   input wire logic local_wake_evt,
   input wire logic remote_wake_evt,
   input wire mode_t mode,
   input wire logic fault_out_n,
   input wire logic rxd_out,
   input wire logic bus_drive_dominant,
   input wire logic bus_driver_en,
   input wire logic wake_src_local,
   input wire flags_t flags
);
   logic drv_block;
   logic local_any;
   // flags that hold the driver off, and all local faults
   assign drv_block = flags.tx_clamped_flag | flags.tx_dominant_timeout_flag
      | flags.tx_rx_short_flag | flags.overtemp_flag;
   assign local_any = drv_block | flags.bus_stuck_dominant_flag;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   drv_gate_a: assert property (bus_driver_en ==
      (mode == MODE_NORMAL && !drv_block)) else $error("driver enable wrong");
   dom_drive_a: assert property (bus_drive_dominant |-> bus_driver_en)
      else $error("dominant drive while driver off");
   sleep_block_a: assert property (flags.wake_request_flag &&
      mode_req == MODE_GO_SLEEP && mode != MODE_GO_SLEEP
      |=> mode == $past(mode)) else $error("go-to-sleep not held off");
   norm_entry_a: assert property (mode == MODE_NORMAL &&
      $past(mode) != MODE_NORMAL |-> !flags.cold_start_flag)
      else $error("power-up flag kept in normal");
   short_rpt_a: assert property (mode == MODE_NORMAL &&
      flags.bus_short_flag |-> !fault_out_n) else $error("bus short unseen");
   short_mode_a: assert property (flags.bus_short_flag |->
      mode == MODE_NORMAL) else $error("bus short kept outside normal");
   remote_wake_a: assert property (mode == MODE_NORMAL &&
      flags.wake_source_flag && !wake_src_local && !flags.bus_short_flag
      |-> fault_out_n) else $error("remote wake shown low");
   quiet_modes_a: assert property (mode inside {MODE_STANDBY,
      MODE_GO_SLEEP, MODE_SLEEP} && $stable(mode) |-> fault_out_n)
      else $error("fault output low in low-power mode");
   local_rpt_a: assert property ($past(mode) == MODE_NORMAL &&
      mode == MODE_SILENT && $past(local_any) && local_any
      |-> ##[0:1] !fault_out_n) else $error("local fault not shown");
   // main scenarios
   cover property (flags.bus_short_flag && !fault_out_n);
   cover property (flags.tx_dominant_timeout_flag && mode == MODE_SILENT);
   cover property (mode == MODE_NORMAL && flags.wake_source_flag);
endmodule : fault_flags_props

bind can_phy_fault_status_flags fault_flags_props u_props (
   .core_clk(core_clk), .resetn(resetn), .mode_req(mode_req),
   .raw_in(raw_in), .local_wake_evt(local_wake_evt),
   .remote_wake_evt(remote_wake_evt), .mode(mode),
   .fault_out_n(fault_out_n), .rxd_out(rxd_out),
   .bus_drive_dominant(bus_drive_dominant), .bus_driver_en(bus_driver_en),
   .wake_src_local(wake_src_local), .flags(flags));

// File: tb/can_ctrl_model.sv
`timescale 1ns/1ns
module can_ctrl_model (
   input wire logic core_clk,
   input wire logic go,
   input wire logic [2:0] n_bits,
   input wire logic hold_low,
   output logic txd,
   output logic busy
);
   logic [2:0] left_q = 3'h0;
   logic [3:0] ph_q = 4'h0;
   // dominant bits: six cycles low, six cycles high each
   always_ff @(posedge core_clk) begin
      if (go && left_q == 3'h0) begin
         left_q <= n_bits;
         ph_q <= 4'h0;
      end else if (left_q != 3'h0) begin
         ph_q <= (ph_q == 4'hb) ? 4'h0 : ph_q + 4'h1;
         if (ph_q == 4'hb) left_q <= left_q - 3'h1;
      end
   end
   assign txd = !hold_low && !(left_q != 3'h0 && ph_q < 4'h6);
   assign busy = left_q != 3'h0;
endmodule : can_ctrl_model

// File: tb/can_phy_fault_status_flags_tb.sv
`timescale 1ns/1ns
module can_phy_fault_status_flags_tb
   import fault_flags_pkg::*;
;
   typedef struct packed {
      mode_t req;
      mode_t m;
      logic fn;
      logic en;
   } row_t;
   logic core_clk = 1'b0;
   logic resetn = 1'b0;
   mode_t mode_req = MODE_STANDBY;
   analog_in_t ain = '0;
   analog_in_t raw_in;
   logic lwake = 1'b0;
   logic rwake = 1'b0;
   logic go = 1'b0;
   logic hold = 1'b0;
   logic [2:0] nb = 3'h0;
   logic txd, busy, fault_out_n, rxd_out, drv_dom, drv_en, wsl;
   mode_t mode;
   flags_t flags;
   int err_total = 0;
   int n_tests = 0;
   row_t rows [8] = '{
      '{MODE_GO_SLEEP, MODE_STANDBY, 1'b1, 1'b0},
      '{MODE_SILENT, MODE_SILENT, 1'b0, 1'b0},
      '{MODE_NORMAL, MODE_NORMAL, 1'b0, 1'b1},
      '{MODE_SILENT, MODE_SILENT, 1'b1, 1'b0},
      '{MODE_STANDBY, MODE_STANDBY, 1'b1, 1'b0},
      '{MODE_GO_SLEEP, MODE_GO_SLEEP, 1'b1, 1'b0},
      '{MODE_SLEEP, MODE_SLEEP, 1'b1, 1'b0},
      '{MODE_NORMAL, MODE_NORMAL, 1'b1, 1'b1}};
   // clock and pin merge
   always #10 core_clk = ~core_clk;
   always_comb begin
      raw_in = ain;
      raw_in.txd = txd;
   end
   can_ctrl_model u_ctrl (.core_clk(core_clk), .go(go), .n_bits(nb),
      .hold_low(hold), .txd(txd), .busy(busy));
   can_phy_fault_status_flags #(.TICK_DIV(2), .TX_DOM_TICKS(5),
      .BUS_DOM_TICKS(6), .UV_TICKS(3)) u_dut (.core_clk(core_clk),
      .resetn(resetn), .mode_req(mode_req), .raw_in(raw_in),
      .local_wake_evt(lwake), .remote_wake_evt(rwake), .mode(mode),
      .fault_out_n(fault_out_n), .rxd_out(rxd_out),
      .bus_drive_dominant(drv_dom), .bus_driver_en(drv_en),
      .wake_src_local(wsl), .flags(flags));
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : conclude
   task automatic chk(input string nm, input logic [10:0] seen,
      input logic [10:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : cyc
   task automatic go_mode(input mode_t m);
      @(posedge core_clk) mode_req <= m;
      cyc(3);
   endtask : go_mode
   task automatic pulses(input logic [2:0] n);
      @(posedge core_clk) begin
         go <= 1'b1;
         nb <= n;
      end
      @(posedge core_clk) go <= 1'b0;
      #1;
      for (int i = 0; i < 200 && busy; i++) cyc(1);
      if (busy) begin
         err_total++;
         conclude();
      end
      cyc(4);
   endtask : pulses
   initial begin
      cyc(2);
      @(posedge core_clk) resetn <= 1'b1;
      cyc(1);
      foreach (rows[i]) begin
         go_mode(rows[i].req);
         chk("mode", 11'(mode), 11'(rows[i].m));
         chk("fault_out_n", 11'(fault_out_n), 11'(rows[i].fn));
         chk("driver_en", 11'(drv_en), 11'(rows[i].en));
      end
      @(posedge core_clk) ain.bus_short <= 1'b1;
      pulses(3'h3);
      chk("bus_short", 11'(flags.bus_short_flag), 11'h0);
      pulses(3'h1);
      chk("bus_short", 11'(flags.bus_short_flag), 11'h1);
      chk("fault_out_n", 11'(fault_out_n), 11'h0);
      @(posedge core_clk) ain.bus_short <= 1'b0;
      pulses(3'h3);
      chk("bus_short", 11'(flags.bus_short_flag), 11'h1);
      pulses(3'h1);
      chk("bus_short", 11'(flags.bus_short_flag), 11'h0);
      @(posedge core_clk) hold <= 1'b1;
      cyc(3);
      chk("drive_dom", 11'(drv_dom), 11'h1);
      cyc(27);
      chk("tx_timeout", 11'(flags.tx_dominant_timeout_flag), 11'h1);
      chk("driver_en", 11'(drv_en), 11'h0);
      chk("drive_dom", 11'(drv_dom), 11'h0);
      go_mode(MODE_SILENT);
      chk("fault_out_n", 11'(fault_out_n), 11'h0);
      @(posedge core_clk) hold <= 1'b0;
      cyc(4);
      go_mode(MODE_NORMAL);
      chk("tx_timeout", 11'(flags.tx_dominant_timeout_flag), 11'h0);
      chk("fault_out_n", 11'(fault_out_n), 11'h1);
      go_mode(MODE_SILENT);
      @(posedge core_clk) hold <= 1'b1;
      cyc(4);
      go_mode(MODE_NORMAL);
      chk("tx_clamped", 11'(flags.tx_clamped_flag), 11'h1);
      chk("driver_en", 11'(drv_en), 11'h0);
      chk("rxd_out", 11'(rxd_out), 11'h1);
      @(posedge core_clk) hold <= 1'b0;
      cyc(4);
      go_mode(MODE_SILENT);
      go_mode(MODE_NORMAL);
      chk("tx_clamped", 11'(flags.tx_clamped_flag), 11'h0);
      @(posedge core_clk) ain.ot_hot <= 1'b1;
      cyc(5);
      chk("overtemp", 11'(flags.overtemp_flag), 11'h1);
      chk("driver_en", 11'(drv_en), 11'h0);
      @(posedge core_clk) ain.ot_hot <= 1'b0;
      go_mode(MODE_STANDBY);
      go_mode(MODE_NORMAL);
      chk("overtemp", 11'(flags.overtemp_flag), 11'h0);
      @(posedge core_clk) ain.bus_dom <= 1'b1;
      cyc(25);
      chk("bus_stuck", 11'(flags.bus_stuck_dominant_flag), 11'h1);
      chk("driver_en", 11'(drv_en), 11'h1);
      @(posedge core_clk) ain.bus_dom <= 1'b0;
      cyc(5);
      chk("bus_stuck", 11'(flags.bus_stuck_dominant_flag), 11'h0);
      @(posedge core_clk) ain.io_low <= 1'b1;
      cyc(15);
      chk("io_low", 11'(flags.io_supply_low_flag), 11'h1);
      chk("fault_out_n", 11'(fault_out_n), 11'h1);
      @(posedge core_clk) ain.io_low <= 1'b0;
      go_mode(MODE_STANDBY);
      @(posedge core_clk) rwake <= 1'b1;
      @(posedge core_clk) begin
         rwake <= 1'b0;
         lwake <= 1'b1;
      end
      @(posedge core_clk) lwake <= 1'b0;
      cyc(3);
      chk("io_low", 11'(flags.io_supply_low_flag), 11'h0);
      chk("rxd_out", 11'(rxd_out), 11'h0);
      go_mode(MODE_NORMAL);
      chk("wake_local", 11'(wsl), 11'h0);
      chk("fault_out_n", 11'(fault_out_n), 11'h1);
      @(posedge core_clk) ain.bat_low <= 1'b1;
      cyc(4);
      @(posedge core_clk) ain.bat_ok <= 1'b1;
      cyc(5);
      chk("cold_start", 11'(flags.cold_start_flag), 11'h1);
      @(posedge core_clk) begin
         resetn <= 1'b0;
         ain <= '0;
         mode_req <= MODE_STANDBY;
      end
      cyc(2);
      @(posedge core_clk) resetn <= 1'b1;
      cyc(1);
      chk("flags", flags, 11'h007);
      chk("mode", 11'(mode), 11'(MODE_STANDBY));
      conclude();
   end
endmodule : can_phy_fault_status_flags_tb
